// *** design/dacs_top.sv ***
// Dual converter sequencer: AHB-Lite registers, triggers, results and interrupts.
`timescale 1ns/1ns
`default_nettype none
module dacs_top (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              hsel_i,
    input  wire logic [31:0]       haddr_i,
    input  wire logic [1:0]        htrans_i,
    input  wire logic              hwrite_i,
    input  wire logic [2:0]        hsize_i,
    input  wire logic [31:0]       hwdata_i,
    input  wire logic              hready_i,
    input  wire logic              ctrl_master_i,
    output logic [31:0]            hrdata_o,
    output logic                   hreadyout_o,
    output logic                   hresp_o,
    input  wire logic [7:0]        ext_trig_i,
    input  wire logic [1:0]        conv_done_i,
    input  wire logic [1:0][11:0]  result_a_i,
    input  wire logic [1:0][11:0]  result_b_i,
    output logic [1:0]             sample_o,
    output logic [1:0]             convert_o,
    output logic [1:0][2:0]        mux_a_sel_o,
    output logic [1:0][2:0]        mux_b_sel_o,
    output logic                   irq_o,
    output logic [7:0]             conv_done_irq_o
);
    localparam int M = dacs_pkg::NUM_MOD;
    localparam int C = dacs_pkg::NUM_CH;

    logic [31:0] slot_reg  [M][C], slot_next  [M][C];
    logic [11:0] res_reg   [M][C], res_next   [M][C];
    logic [7:0]  pair_reg  [M], pair_next  [M];
    logic [31:0] itrig_reg [M], itrig_next [M];
    logic        prio_reg  [M], prio_next  [M];
    logic [31:0] route_reg [M][2], route_next [M][2];
    logic [15:0] pend_reg  [M], pend_next  [M];
    logic [15:0] stat_reg, stat_next, en_reg, en_next;
    logic [7:0]  ext_prev_reg;
    logic [2:0]  div_reg, div_next;
    logic        tick;
    logic        wr_pend_reg, ctrl_ok_reg;
    logic [11:0] addr_reg;
    logic [31:0] rdata_next;
    logic        irq_next;
    logic [7:0]  and_next;
    logic [2:0]  mux_a_next [M], mux_b_next [M];
    logic [7:0]  ext_rise;
    logic [1:0]  take, fin;
    logic [3:0]  chan [M];
    logic [6:0]  win  [M];
    logic [7:0]  ievt [M];
    logic [15:0] done_mask [M];
    logic        addr_ok;

    assign addr_ok = hsel_i && hready_i && htrans_i[1];
    assign ext_rise = ext_trig_i & ~ext_prev_reg;
    assign tick = (div_reg == 3'(dacs_pkg::ADC_DIV - 1));

    // Register read decode; results answer every master, the rest only the control side.
    function automatic logic [31:0] rd(input logic [11:0] a);
        logic [0:0] m;
        logic [7:0] o;
        m = a[8];
        o = a[7:0];
        rd = 32'h0000_0000;
        if (a[11:9] == 3'h0)
        begin
            if (o < dacs_pkg::OFF_PAIR[7:0])
                rd = slot_reg[m][o[5:2]];
            else if (o == dacs_pkg::OFF_PAIR[7:0])
                rd = {24'h00_0000, pair_reg[m]};
            else if (o == dacs_pkg::OFF_ITRIG[7:0])
                rd = itrig_reg[m];
            else if (o == dacs_pkg::OFF_PRIO[7:0])
                rd = {31'h0000_0000, prio_reg[m]};
            else if (o == dacs_pkg::OFF_ROUTE0[7:0])
                rd = route_reg[m][0];
            else if (o == dacs_pkg::OFF_ROUTE1[7:0])
                rd = route_reg[m][1];
            else if (o >= dacs_pkg::OFF_RESULT[7:0] && o[7:6] == 2'h2)
                rd = {20'h0_0000, res_reg[m][o[5:2]]};
        end
        else if (a == dacs_pkg::OFF_STAT)
            rd = {16'h0000, stat_reg};
        else if (a == dacs_pkg::OFF_EN)
            rd = {16'h0000, en_reg};
        else if (a == dacs_pkg::OFF_AND)
            rd = {24'h00_0000, conv_done_irq_o};
    endfunction

    // One arbiter and sequencer per converter module.
    for (genvar g = 0; g < M; g++)
    begin : g_mod
        dacs_seq u_seq (
            .clk_i     (clk_i),
            .rst_n_i   (rst_n_i),
            .tick_i    (tick),
            .pend_i    (pend_reg[g]),
            .rr_i      (prio_reg[g]),
            .window_i  (win[g]),
            .done_i    (conv_done_i[g]),
            .take_o    (take[g]),
            .chan_o    (chan[g]),
            .sample_o  (sample_o[g]),
            .convert_o (convert_o[g]),
            .finish_o  (fin[g])
        );
    end

    // Configuration, triggers, results and flags; reads are served at the address phase.
    always_comb
    begin
        logic [11:0] a;
        logic [3:0]  sel;
        logic [3:0]  rc;
        logic [1:0]  src;
        logic        hit;
        logic        pr;
        sel = 4'h0;
        rc = 4'h0;
        src = 2'h0;
        hit = 1'b0;
        pr = 1'b0;
        a = addr_reg - (addr_reg[8] ? dacs_pkg::MOD_STRIDE : 12'h000);
        div_next = tick ? 3'h0 : div_reg + 3'h1;
        stat_next = stat_reg;
        en_next = en_reg;
        rdata_next = addr_ok && !hwrite_i ? rd(haddr_i[11:0]) : hrdata_o;
        // Other masters see only the result window; configuration reads back as zero.
        if (addr_ok && !hwrite_i && !ctrl_master_i && haddr_i[7:6] != 2'h2)
            rdata_next = 32'h0000_0000;
        for (int m = 0; m < M; m++)
        begin
            slot_next[m] = slot_reg[m];
            res_next[m] = res_reg[m];
            pair_next[m] = pair_reg[m];
            itrig_next[m] = itrig_reg[m];
            prio_next[m] = prio_reg[m];
            route_next[m] = route_reg[m];
            // Pair mode takes the even slot; the odd slot then does nothing.
            sel = slot_reg[m][chan[m]][dacs_pkg::SEL_LSB +: 4];
            pr = pair_reg[m][chan[m][3:1]];
            win[m] = slot_reg[m][chan[m]][dacs_pkg::WIN_LSB +: 7];
            mux_a_next[m] = (sel[2:0] > dacs_pkg::MUX_A_MAX) ? dacs_pkg::MUX_A_MAX
                                                            : sel[2:0];
            mux_b_next[m] = (sel[2:0] > dacs_pkg::MUX_B_REF) ? dacs_pkg::MUX_B_REF
                                                            : sel[2:0];
            if (pr)
                mux_b_next[m] = mux_a_next[m];
            // Completion mask covers both channels of a pair.
            done_mask[m] = 16'h0000;
            if (fin[m])
            begin
                done_mask[m][chan[m]] = 1'b1;
                if (pr)
                begin
                    done_mask[m][chan[m] | 4'h1] = 1'b1;
                    res_next[m][chan[m]] = result_a_i[m];
                    res_next[m][chan[m] | 4'h1] = result_b_i[m];
                end
                else
                    res_next[m][chan[m]] = sel[3] ? result_b_i[m] : result_a_i[m];
            end
            for (int k = 0; k < dacs_pkg::NUM_IRQ; k++)
            begin
                rc = route_reg[m][k / 4][(k % 4) * 8 +: 4];
                ievt[m][k] = route_reg[m][k / 4][(k % 4) * 8 + dacs_pkg::ROUTE_EN]
                             && done_mask[m][rc];
            end
            // Pending flags: a new trigger wins over the clear of the served one.
            for (int c = 0; c < C; c++)
            begin
                src = itrig_reg[m][2 * c +: 2];
                if (src == dacs_pkg::ITRIG_IRQ0)
                    hit = ievt[m][0];
                else if (src == dacs_pkg::ITRIG_IRQ1)
                    hit = ievt[m][1];
                else
                    hit = ext_rise[slot_reg[m][c][dacs_pkg::TRIG_LSB +: 3]];
                pend_next[m][c] = ((pend_reg[m][c] && !(take[m] && chan[m] == 4'(c))) || hit)
                                  && !(pair_reg[m][c / 2] && c[0]);
            end
        end
        stat_next = (stat_reg & ~((wr_pend_reg && ctrl_ok_reg && addr_reg == dacs_pkg::OFF_CLR)
                    ? hwdata_i[15:0] : 16'h0000)) | {ievt[1], ievt[0]};
        // Configuration writes from any other master are dropped.
        if (wr_pend_reg && ctrl_ok_reg)
        begin
            if (addr_reg[11:9] == 3'h0)
            begin
                if (a < dacs_pkg::OFF_PAIR)
                    slot_next[addr_reg[8]][a[5:2]] = hwdata_i;
                else if (a == dacs_pkg::OFF_PAIR)
                    pair_next[addr_reg[8]] = hwdata_i[7:0];
                else if (a == dacs_pkg::OFF_ITRIG)
                    itrig_next[addr_reg[8]] = hwdata_i;
                else if (a == dacs_pkg::OFF_PRIO)
                    prio_next[addr_reg[8]] = hwdata_i[0];
                else if (a == dacs_pkg::OFF_ROUTE0)
                    route_next[addr_reg[8]][0] = hwdata_i;
                else if (a == dacs_pkg::OFF_ROUTE1)
                    route_next[addr_reg[8]][1] = hwdata_i;
            end
            else if (addr_reg == dacs_pkg::OFF_EN)
                en_next = hwdata_i[15:0];
        end
        irq_next = |(stat_reg & en_reg);
        and_next = stat_reg[7:0] & stat_reg[15:8];
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int m = 0; m < M; m++)
            begin
                for (int c = 0; c < C; c++)
                begin
                    slot_reg[m][c] <= dacs_pkg::SLOT_RST;
                    res_reg[m][c] <= 12'h000;
                end
                pair_reg[m] <= 8'h00;
                itrig_reg[m] <= 32'h0000_0000;
                prio_reg[m] <= 1'b0;
                route_reg[m][0] <= 32'h0000_0000;
                route_reg[m][1] <= 32'h0000_0000;
                pend_reg[m] <= 16'h0000;
                mux_a_sel_o[m] <= 3'h0;
                mux_b_sel_o[m] <= 3'h0;
            end
            stat_reg <= 16'h0000;
            en_reg <= 16'h0000;
            ext_prev_reg <= 8'h00;
            div_reg <= 3'h0;
            wr_pend_reg <= 1'b0;
            ctrl_ok_reg <= 1'b0;
            addr_reg <= 12'h000;
            hrdata_o <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            irq_o <= 1'b0;
            conv_done_irq_o <= 8'h00;
        end
        else
        begin
            for (int m = 0; m < M; m++)
            begin
                slot_reg[m] <= slot_next[m];
                res_reg[m] <= res_next[m];
                pair_reg[m] <= pair_next[m];
                itrig_reg[m] <= itrig_next[m];
                prio_reg[m] <= prio_next[m];
                route_reg[m] <= route_next[m];
                pend_reg[m] <= pend_next[m];
                mux_a_sel_o[m] <= mux_a_next[m];
                mux_b_sel_o[m] <= mux_b_next[m];
            end
            stat_reg <= stat_next;
            en_reg <= en_next;
            ext_prev_reg <= ext_trig_i;
            div_reg <= div_next;
            wr_pend_reg <= addr_ok && hwrite_i;
            ctrl_ok_reg <= ctrl_master_i;
            addr_reg <= addr_ok ? haddr_i[11:0] : addr_reg;
            hrdata_o <= rdata_next;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            irq_o <= irq_next;
            conv_done_irq_o <= and_next;
        end
    end

    // Checks on module 0; module 1 is the same logic.
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_conv_after_sample: assert property ($fell(sample_o[0]) |-> convert_o[0])
        else $error("sample ended without a conversion start");
    a_ext_trig_pend: assert property ((ext_rise[2] && itrig_reg[0][1:0] == 2'h0
        && slot_reg[0][0][10:8] == 3'h2 && !pair_reg[0][0]) |=> pend_reg[0][0])
        else $error("external trigger not latched as pending");
    a_odd_ignored: assert property (pair_reg[0][1] |=> !pend_reg[0][3] || !pair_reg[0][1])
        else $error("odd channel of a pair became pending");
    a_pair_result: assert property ((fin[0] && chan[0] == 4'h2 && pair_reg[0][1])
        |=> res_reg[0][3] == $past(result_b_i[0]) && res_reg[0][2] == $past(result_a_i[0]))
        else $error("pair results not stored in both registers");
    a_route_flag: assert property ((fin[0] && route_reg[0][0][7] && route_reg[0][0][3:0] == chan[0])
        |=> stat_reg[0])
        else $error("routed completion did not set its flag");
    a_and_combine: assert property (##1 conv_done_irq_o == $past(stat_reg[7:0] & stat_reg[15:8]))
        else $error("combined done irq mismatch");
    a_cfg_guard: assert property ((wr_pend_reg && !ctrl_ok_reg) |=> $stable(pair_reg[0])
        && $stable(prio_reg[0]) && $stable(slot_reg[0][4]))
        else $error("configuration changed by non-control master");
    a_mux_range: assert property (mux_a_sel_o[0] <= 3'h5 && mux_b_sel_o[0] <= 3'h6)
        else $error("mux select out of range");
    a_pair_mux: assert property ((sample_o[0] && pair_reg[0][chan[0][3:1]])
        |-> mux_a_sel_o[0] == mux_b_sel_o[0])
        else $error("pair mode muxes differ");
    c_pair_conv: cover property (fin[0] && pair_reg[0][chan[0][3:1]]);
    c_chain_trig: cover property (ievt[0][0] && itrig_reg[0][1:0] == 2'h1);
    c_both_done: cover property (|conv_done_irq_o);
endmodule
`default_nettype wire

// *** design/dacs_pkg.sv ***
// Constants shared by the dual converter sequencer.
// Behaviour
// - Each converter has 16 channels, each with own input, trigger and window; irqs come via routes.
// - Pair bit 0: even and odd channel convert independently with own settings.
// - Pair bit 1: even slot configures both channels, odd slot ignored, two results.
// - In pair mode the even input select picks the same input for both multiplexers.
// - Any mix of independent channels and pairs is allowed.
// - Eight external triggers plus two internal ones from irq 0 and 1.
// - Per channel select picks external trigger or one of the two internal ones.
// - External channels use their trigger source field to pick one of eight.
// - One 12-bit conversion at a time per converter, ordered by the priority control.
// - Mux A picks among six inputs, mux B among six plus low reference.
// - Sixteen result registers per module, each channel writes its own.
// - Route selects map channel completions onto eight done irqs per module.
// - Matching done irqs of both modules are AND-ed onto conv_done_irq_o; irq_o is the OR of the enabled flags.
// - Results readable by all masters, configuration only by the control side.
package dacs_pkg;
    localparam int NUM_MOD = 2;
    localparam int NUM_CH  = 16;
    localparam int NUM_IRQ = 8;
    localparam int RES_W   = 12;
    // Converter clock derived from the system clock, rounded to stay under the maximum.
    localparam int SYS_CLK_KHZ     = 250000;
    localparam int ADC_CLK_MAX_KHZ = 37500;
    localparam int ADC_DIV = (SYS_CLK_KHZ + ADC_CLK_MAX_KHZ - 1) / ADC_CLK_MAX_KHZ;
    localparam logic [6:0] WIN_MIN = 7'h07;
    localparam logic [6:0] WIN_MAX = 7'h40;
    // Byte offsets inside one module window, module 1 adding MOD_STRIDE; OFF_STAT to OFF_AND are shared by both.
    localparam logic [11:0] MOD_STRIDE = 12'h100;
    localparam logic [11:0] OFF_SLOT   = 12'h000;
    localparam logic [11:0] OFF_PAIR   = 12'h040;
    localparam logic [11:0] OFF_ITRIG  = 12'h044;
    localparam logic [11:0] OFF_PRIO   = 12'h048;
    localparam logic [11:0] OFF_ROUTE0 = 12'h04C;
    localparam logic [11:0] OFF_ROUTE1 = 12'h050;
    localparam logic [11:0] OFF_RESULT = 12'h080;
    localparam logic [11:0] OFF_STAT   = 12'h200;
    localparam logic [11:0] OFF_EN     = 12'h204;
    localparam logic [11:0] OFF_CLR    = 12'h208;
    localparam logic [11:0] OFF_AND    = 12'h20C;
    // Slot control fields.
    localparam int SEL_LSB  = 0;
    localparam int TRIG_LSB = 8;
    localparam int WIN_LSB  = 16;
    localparam logic [31:0] SLOT_RST = 32'h0007_0000;
    // Route byte: channel in bits 3:0, enable in bit 7.
    localparam int ROUTE_EN = 7;
    // Mux codes.
    localparam logic [2:0] MUX_A_MAX = 3'h5;
    localparam logic [2:0] MUX_B_REF = 3'h6;
    // Internal trigger select codes, two bits per channel.
    localparam logic [1:0] ITRIG_EXT  = 2'h0;
    localparam logic [1:0] ITRIG_IRQ0 = 2'h1;
    localparam logic [1:0] ITRIG_IRQ1 = 2'h2;
endpackage

// *** design/dacs_seq.sv ***
// Per-module arbiter and sample/convert sequencer.
`timescale 1ns/1ns
`default_nettype none
module dacs_seq (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        tick_i,
    input  wire logic [15:0] pend_i,
    input  wire logic        rr_i,
    input  wire logic [6:0]  window_i,
    input  wire logic        done_i,
    output logic             take_o,
    output logic [3:0]       chan_o,
    output logic             sample_o,
    output logic             convert_o,
    output logic             finish_o
);
    typedef enum logic [1:0] {DACS_IDLE, DACS_LOAD, DACS_SAMPLE, DACS_CONV} dacs_state_t;
    dacs_state_t state_reg, state_next;
    logic [6:0]  cnt_reg, cnt_next;
    logic [3:0]  last_reg, last_next, chan_next;
    logic        take_next, sample_next, convert_next, finish_next;

    // First pending channel at or after the base, wrapping at 16.
    function automatic logic [3:0] pick(input logic [15:0] p, input logic [3:0] base);
        logic [3:0] idx;
        logic       found;
        pick = base;
        found = 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            idx = base + 4'(i);
            if (!found && p[idx])
            begin
                pick = idx;
                found = 1'b1;
            end
        end
    endfunction

    // Only one channel is in flight; the converter never overlaps two.
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        last_next = last_reg;
        chan_next = chan_o;
        take_next = 1'b0;
        sample_next = sample_o;
        convert_next = 1'b0;
        finish_next = 1'b0;
        unique case (state_reg)
            DACS_IDLE:
                if (|pend_i)
                begin
                    chan_next = pick(pend_i, rr_i ? last_reg + 4'h1 : 4'h0);
                    take_next = 1'b1;
                    state_next = DACS_LOAD;
                end
            DACS_LOAD:
            begin
                // A zero window would wrap the counter and last 128 clocks, so it runs as one clock.
                cnt_next = (window_i == 7'h00) ? 7'h01 : window_i;
                sample_next = 1'b1;
                state_next = DACS_SAMPLE;
            end
            DACS_SAMPLE:
                if (tick_i)
                begin
                    if (cnt_reg == 7'h01)
                    begin
                        sample_next = 1'b0;
                        convert_next = 1'b1;
                        state_next = DACS_CONV;
                    end
                    else
                        cnt_next = cnt_reg - 7'h01;
                end
            DACS_CONV:
                if (done_i)
                begin
                    finish_next = 1'b1;
                    last_next = chan_o;
                    state_next = DACS_IDLE;
                end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_reg <= DACS_IDLE;
            cnt_reg <= 7'h00;
            last_reg <= 4'hF;
            chan_o <= 4'h0;
            take_o <= 1'b0;
            sample_o <= 1'b0;
            convert_o <= 1'b0;
            finish_o <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            last_reg <= last_next;
            chan_o <= chan_next;
            take_o <= take_next;
            sample_o <= sample_next;
            convert_o <= convert_next;
            finish_o <= finish_next;
        end
    end
endmodule
`default_nettype wire

// *** bench/dacs_core_model.sv ***
// Behavioural analog core: answers each convert pulse with one done pulse.
`timescale 1ns/1ns
`default_nettype none
module dacs_core_model #(
    parameter int CONV_LAT = 13
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [1:0]       convert_i,
    input  wire logic [1:0][2:0]  mux_a_i,
    input  wire logic [1:0][2:0]  mux_b_i,
    output logic      [1:0]       conv_done_o,
    output logic      [1:0][11:0] result_a_o,
    output logic      [1:0][11:0] result_b_o
);
    logic [1:0][4:0] cnt;
    logic [1:0][2:0] cap_a;
    logic [1:0][2:0] cap_b;
    // Results hold from the done pulse on, since the sequencer stores them two clocks later.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt <= '0;
            cap_a <= '0;
            cap_b <= '0;
            conv_done_o <= '0;
            result_a_o <= '0;
            result_b_o <= '0;
        end
        else
        begin
            for (int m = 0; m < 2; m++)
            begin
                conv_done_o[m] <= 1'b0;
                if (convert_i[m])
                begin
                    cnt[m] <= 5'(CONV_LAT);
                    cap_a[m] <= mux_a_i[m];
                    cap_b[m] <= mux_b_i[m];
                end
                else if (cnt[m] != 5'h00)
                begin
                    cnt[m] <= cnt[m] - 5'h01;
                end
                if (!convert_i[m] && cnt[m] == 5'h01)
                begin
                    conv_done_o[m] <= 1'b1;
                    result_a_o[m] <= {8'hA0, 1'(m), cap_a[m]};
                    result_b_o[m] <= {8'hB0, 1'(m), cap_b[m]};
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// Self-checking bench for the dual converter sequencer.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module tb;
    logic clk_i, rst_n_i, hwrite, ctrl, hready, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans, smp, cnv, done;
    logic [7:0] trig, cdi;
    logic [1:0][11:0] ra, rb;
    logic [1:0][2:0] ma, mb;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;
    dacs_top uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(1'b1), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .ctrl_master_i(ctrl), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp), .ext_trig_i(trig), .conv_done_i(done), .result_a_i(ra),
        .result_b_i(rb), .sample_o(smp), .convert_o(cnv), .mux_a_sel_o(ma),
        .mux_b_sel_o(mb), .irq_o(irq), .conv_done_irq_o(cdi));
    dacs_core_model core (.clk_i(clk_i), .rst_n_i(rst_n_i), .convert_i(cnv), .mux_a_i(ma),
        .mux_b_i(mb), .conv_done_o(done), .result_a_o(ra), .result_b_o(rb));
    // One AHB-Lite single transfer; waits on hready in both phases.
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_i);
        htrans <= 2'h2; haddr <= a; hwrite <= w;
        do @(posedge clk_i); while (hready !== 1'b1);
        htrans <= 2'h0; hwdata <= d;
        do @(posedge clk_i); while (hready !== 1'b1);
        r = hrdata;
    endtask
    function automatic logic [31:0] ad(input int m, input logic [11:0] off);
        return {20'h0, off + (m != 0 ? dacs_pkg::MOD_STRIDE : 12'h000)};
    endfunction
    // Polls status until all bits of the mask are set, bounded.
    task automatic wait_st(input logic [31:0] mask);
        for (int i = 0; i < 400; i++)
        begin
            ahb(1'b0, ad(0, dacs_pkg::OFF_STAT), 32'h0);
            if ((r & mask) === mask) break;
        end
    endtask
    task automatic pulse(input int k);
        @(posedge clk_i);
        trig[k] <= 1'b1;
        @(posedge clk_i);
        trig[k] <= 1'b0;
    endtask
    task automatic test_reset();
        ahb(1'b0, ad(0, 12'h000), 32'h0); `CHK(r, dacs_pkg::SLOT_RST)
        ahb(1'b0, ad(1, dacs_pkg::OFF_PAIR), 32'h0); `CHK(r, 32'h0)
        ahb(1'b0, ad(0, 12'h3F0), 32'h0); `CHK(r, 32'h0)
        `CHK(hresp, 1'b0)
        `CHK(hready, 1'b1)
        $display("test_reset done");
    endtask
    task automatic test_gate();
        ctrl <= 1'b0;
        ahb(1'b1, ad(0, 12'h010), 32'h0000_0101);
        ctrl <= 1'b1;
        ahb(1'b0, ad(0, 12'h010), 32'h0); `CHK(r, dacs_pkg::SLOT_RST)
        $display("test_gate done");
    endtask
    task automatic test_chain();
        // Window of 7 converter clocks keeps software inside the legal range.
        ahb(1'b1, ad(0, 12'h000), 32'h0007_0203);
        ahb(1'b1, ad(1, 12'h000), 32'h0007_0203);
        ahb(1'b1, ad(0, 12'h004), 32'h0007_0001);
        ahb(1'b1, ad(0, dacs_pkg::OFF_ITRIG), 32'(dacs_pkg::ITRIG_IRQ0) << 2);
        ahb(1'b1, ad(0, dacs_pkg::OFF_ROUTE0), 32'h0000_8180);
        ahb(1'b1, ad(1, dacs_pkg::OFF_ROUTE0), 32'h0000_0080);
        ahb(1'b1, ad(0, dacs_pkg::OFF_EN), 32'h0000_0001);
        pulse(2);
        wait_st(32'h0000_0101); `CHK(r & 32'h0101, 32'h0101)
        `CHK(cdi[0], 1'b1)
        `CHK(irq, 1'b1)
        ahb(1'b0, ad(0, 12'h080), 32'h0); `CHK(r[11:0], 12'hA03)
        ahb(1'b0, ad(1, 12'h080), 32'h0); `CHK(r[11:0], 12'hA0B)
        wait_st(32'h0000_0002);
        ahb(1'b0, ad(0, 12'h084), 32'h0); `CHK(r[11:0], 12'hA01)
        ahb(1'b1, ad(0, dacs_pkg::OFF_EN), 32'h0);
        ahb(1'b0, ad(0, dacs_pkg::OFF_STAT), 32'h0); `CHK(irq, 1'b0)
        ahb(1'b1, ad(0, dacs_pkg::OFF_CLR), 32'h0000_0103);
        ahb(1'b0, ad(0, dacs_pkg::OFF_STAT), 32'h0); `CHK(r, 32'h0)
        `CHK(cdi[0], 1'b0)
        $display("test_chain done");
    endtask
    task automatic test_pair();
        ahb(1'b1, ad(0, dacs_pkg::OFF_ITRIG), 32'h0);
        ahb(1'b1, ad(0, dacs_pkg::OFF_PAIR), 32'h0000_0002);
        ahb(1'b1, ad(0, 12'h008), 32'h0007_0504);
        ahb(1'b1, ad(0, 12'h00C), 32'h0007_0500);
        ahb(1'b1, ad(0, 12'h018), 32'h0007_050A);
        ahb(1'b1, ad(0, dacs_pkg::OFF_ROUTE0), 32'h8682_0000);
        pulse(5);
        wait_st(32'h0000_0004); `CHK(r[3], 1'b0)
        wait_st(32'h0000_0008); `CHK(r[3], 1'b1)
        ctrl <= 1'b0;
        ahb(1'b0, ad(0, 12'h088), 32'h0); `CHK(r[11:0], 12'hA04)
        ahb(1'b0, ad(0, 12'h08C), 32'h0); `CHK(r[11:0], 12'hB04)
        ahb(1'b0, ad(0, 12'h098), 32'h0); `CHK(r[11:0], 12'hB02)
        ahb(1'b0, ad(0, 12'h008), 32'h0); `CHK(r, 32'h0)
        ctrl <= 1'b1;
        $display("test_pair done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // A hang is cut off well beyond the few hundred cycles the tests need.
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles >= 40000)
        begin
            miscompares++;
            conclude();
        end
    end
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    initial
    begin
        rst_n_i = 1'b0; htrans = 2'h0; haddr = '0; hwrite = 1'b0; hwdata = '0;
        ctrl = 1'b1; trig = '0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        test_reset();
        test_gate();
        test_chain();
        test_pair();
        conclude();
    end
endmodule
`default_nettype wire
